// *** verilog/rodc_pkg.sv ***
// Package: constants, types and register map of the relay block
package rodc_pkg;

    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned TICK_MS      = 100;
    localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TICKS_PER_MIN = 600;
    localparam int unsigned NUM_RELAYS   = 6;
    localparam int unsigned NUM_DIAG     = 19;

    // Diagnostic enable bit positions and their codes
    localparam int unsigned DG_TOT3_HI_ALM = 0;
    localparam int unsigned DG_TOT3_HI_WRN = 1;
    localparam int unsigned DG_TOT3_LO_WRN = 2;
    localparam int unsigned DG_TOT3_LO_ALM = 3;
    localparam int unsigned DG_TOT4_HI_ALM = 4;
    localparam int unsigned DG_TOT4_HI_WRN = 5;
    localparam int unsigned DG_TOT4_LO_WRN = 6;
    localparam int unsigned DG_TOT4_LO_ALM = 7;
    localparam int unsigned DG_LOOP_LO_SAT = 8;
    localparam int unsigned DG_LOOP_HI_SAT = 9;
    localparam int unsigned DG_LOOP_ERR    = 10;
    localparam int unsigned DG_LOOP_BREAK  = 11;
    localparam int unsigned DG_AO1_LO_SAT  = 12;
    localparam int unsigned DG_AO1_HI_SAT  = 13;
    localparam int unsigned DG_AO2_LO_SAT  = 14;
    localparam int unsigned DG_AO2_HI_SAT  = 15;
    localparam int unsigned DG_LOG_30D     = 16;
    localparam int unsigned DG_LOG_7D      = 17;
    localparam int unsigned DG_LOG_FULL    = 18;
    localparam logic [NUM_DIAG-1:0][9:0] DIAG_CODES = {
        10'd287, 10'd286, 10'd285, 10'd202, 10'd201, 10'd196, 10'd195,
        10'd158, 10'd155, 10'd154, 10'd153, 10'd319, 10'd318, 10'd317,
        10'd316, 10'd147, 10'd146, 10'd145, 10'd144};

    // Relay modes
    localparam logic [2:0] MODE_DISABLED = 3'h0;
    localparam logic [2:0] MODE_STATUS   = 3'h1;
    localparam logic [2:0] MODE_ALARM    = 3'h2;
    localparam logic [2:0] MODE_APP      = 3'h3;
    localparam logic [2:0] MODE_EXT_TOT  = 3'h4;
    localparam logic [2:0] MODE_EXT_SMP  = 3'h5;
    localparam logic [2:0] MODE_ELAPSED  = 3'h6;

    localparam logic [1:0] FS_DISABLED = 2'h0;
    localparam logic [1:0] FS_HOLD     = 2'h1;
    localparam logic [1:0] FS_ENERGIZE = 2'h2;
    localparam logic [1:0] FS_DEENERG  = 2'h3;
    localparam logic [1:0] FSRC_BOTH   = 2'h0;
    localparam logic [1:0] FSRC_PT1    = 2'h1;
    localparam logic [1:0] FSRC_PT2    = 2'h2;

    // Register map: relay n at n*0x20, global block at 0xc0
    localparam logic [7:0] RELAY_STRIDE = 8'h20;
    localparam logic [4:0] REG_CTRL     = 5'h00;
    localparam logic [4:0] REG_DIAG_EN  = 5'h04;
    localparam logic [4:0] REG_AMOUNT   = 5'h08;
    localparam logic [4:0] REG_ON_DLY   = 5'h0c;
    localparam logic [4:0] REG_OFF_DLY  = 5'h10;
    localparam logic [4:0] REG_INTERVAL = 5'h14;
    localparam logic [4:0] REG_STATUS   = 5'h18;
    localparam logic [7:0] REG_GLOBAL   = 8'hc0;

    typedef struct packed {
        logic       force_en;
        logic       force_val;
        logic [1:0] pv_sel;
        logic [1:0] fs_src;
        logic       fs_count_good;
        logic [1:0] fs_beh;
        logic       pol_low;
        logic [2:0] mode;
    } rodc_ctrl_t;

    typedef struct packed {
        logic [9:0] hours;
        logic [5:0] minutes;
    } rodc_interval_t;

    // Per-update signed volume increments: vf1, vf2, pumped1, pumped2
    typedef struct packed {
        logic              strobe;
        logic [3:0][24:0]  delta;
    } rodc_proc_t;

    typedef enum logic [2:0] {ST_IDLE, ST_ON_WAIT, ST_ACTIVE, ST_OFF_WAIT, ST_PULSE} rodc_state_t;

    localparam rodc_ctrl_t     CTRL_RST     = '0;
    localparam logic [18:0]    DIAG_EN_RST  = 19'h00000;
    localparam logic [24:0]    AMOUNT_RST   = 25'h00003e8;
    localparam logic [16:0]    ON_DLY_RST   = 17'h00000;
    localparam logic [16:0]    OFF_DLY_RST  = 17'h00005;
    localparam rodc_interval_t INTERVAL_RST = '{hours: 10'h001, minutes: 6'h00};

endpackage

// *** verilog/rodc_relay_ctrl.sv ***
// Six-relay output control: diagnostic triggers, delays, fail-safe, pulses, APB registers
//
// Contract
// R1 - Each relay triggers on any active diagnostic whose enable flag is set.
// R2 - Totalizer three and four limit diagnostics are selectable, each with its code.
// R3 - Loop channel one saturation, error and cable break diagnostics are selectable.
// R4 - Current outputs one and two saturation diagnostics are selectable triggers.
// R5 - Logging thirty days, seven days and memory full diagnostics are selectable.
// R6 - All diagnostic enable flags reset to disabled.
// R7 - Counted value selects flow or pumped volume of point one or two.
// R8 - One pulse per signed programmable volume amount, default 1000.
// R9 - One pulse per hours-plus-minutes interval, default one hour.
// R10 - Fail-safe: disabled, hold, energized or de-energized; disabled at reset.
// R11 - Totalizer modes under fail-safe pause or count latest good value.
// R12 - Fail-safe source is point one, point two or both; both at reset.
// R13 - Output polarity active high or low; active high at reset.
// R14 - Status and alarm modes delay activation by an on-delay, default zero.
// R15 - Deactivation is delayed by an off-delay, default half a second.
// R16 - In pulse modes the off-delay sets the pulse width.
// R17 - Forced value 0 or 1, default 0, driven while forcing.
// R18 - Forcing any relay forces all six relays together.
// R19 - Six relays, each with its own identical parameter set.
// R20 - Condition clearing during on-delay abandons activation and restarts the delay.
// R21 - All timing runs from a common tenth-of-a-second tick.
`timescale 1ns/1ps
`default_nettype none
module rodc_relay_ctrl
    import rodc_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output var  logic [31:0]           prdata,
    output var  logic                  pready,
    output var  logic                  pslverr,
    // Device status from the measurement core
    input  wire logic [NUM_DIAG-1:0]   diag_active,
    input  wire logic [1:0]            point_fail,
    input  wire logic [NUM_RELAYS-1:0] app_req,
    input  wire rodc_proc_t            proc_in,
    // Relay drive
    output var  logic [NUM_RELAYS-1:0] relay_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    rodc_ctrl_t            ctrl_r     [NUM_RELAYS];
    logic [NUM_DIAG-1:0]   diag_en_r  [NUM_RELAYS];
    logic [24:0]           amount_r   [NUM_RELAYS];
    logic [16:0]           on_dly_r   [NUM_RELAYS];
    logic [16:0]           off_dly_r  [NUM_RELAYS];
    rodc_interval_t        interval_r [NUM_RELAYS];
    logic [NUM_RELAYS-1:0] active_r;
    logic [NUM_RELAYS-1:0] fs_seen;
    logic [NUM_RELAYS-1:0] force_any_v;
    logic                  force_any;
    logic [31:0]           prdata_nxt;
    logic                  slverr_nxt;
    logic                  wr_en;
    logic [2:0]            sel_relay;
    logic [4:0]            sel_reg;

    assign sel_relay = paddr[7:5];
    assign sel_reg   = paddr[4:0];
    assign wr_en     = psel && penable && pready && pwrite && !slverr_nxt;

    always_comb begin
        prdata_nxt = 32'h00000000;
        slverr_nxt = 1'b0;
        if (paddr == REG_GLOBAL) begin
            prdata_nxt = {8'h00, 2'b00, fs_seen, 2'b00, active_r, 2'b00, relay_out};
        end else if (sel_relay < 3'(NUM_RELAYS) && paddr[1:0] == 2'b00) begin
            unique case (sel_reg)
                REG_CTRL:     prdata_nxt = 32'(ctrl_r[sel_relay]);
                REG_DIAG_EN:  prdata_nxt = 32'(diag_en_r[sel_relay]);
                REG_AMOUNT:   prdata_nxt = {{7{amount_r[sel_relay][24]}}, amount_r[sel_relay]};
                REG_ON_DLY:   prdata_nxt = 32'(on_dly_r[sel_relay]);
                REG_OFF_DLY:  prdata_nxt = 32'(off_dly_r[sel_relay]);
                REG_INTERVAL: prdata_nxt = {6'h00, interval_r[sel_relay].hours,
                                            10'h000, interval_r[sel_relay].minutes};
                REG_STATUS:   prdata_nxt = {29'h0, fs_seen[sel_relay], active_r[sel_relay],
                                            relay_out[sel_relay]};
                default:      slverr_nxt = 1'b1;
            endcase
        end else begin
            slverr_nxt = 1'b1;
        end
    end

    // One wait state: answer registered the cycle after the access phase starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            prdata  <= (psel && penable && !pready && !pwrite) ? prdata_nxt : 32'h00000000;
            pslverr <= psel && penable && !pready && slverr_nxt;
        end
    end

    // Each relay keeps its own copy of every setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_RELAYS; i++) begin // R19
                ctrl_r[i]     <= CTRL_RST; // R10 R11 R12 R13 R17
                diag_en_r[i]  <= DIAG_EN_RST; // R6
                amount_r[i]   <= AMOUNT_RST; // R8
                on_dly_r[i]   <= ON_DLY_RST; // R14
                off_dly_r[i]  <= OFF_DLY_RST; // R15
                interval_r[i] <= INTERVAL_RST; // R9
            end
        end else if (wr_en && paddr != REG_GLOBAL) begin
            unique case (sel_reg)
                REG_CTRL:     ctrl_r[sel_relay]     <= rodc_ctrl_t'(pwdata[12:0]);
                REG_DIAG_EN:  diag_en_r[sel_relay]  <= pwdata[NUM_DIAG-1:0]; // R1 R2 R3 R4 R5
                REG_AMOUNT:   amount_r[sel_relay]   <= pwdata[24:0];
                REG_ON_DLY:   on_dly_r[sel_relay]   <= pwdata[16:0];
                REG_OFF_DLY:  off_dly_r[sel_relay]  <= pwdata[16:0];
                REG_INTERVAL: interval_r[sel_relay] <= {pwdata[25:16], pwdata[5:0]};
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Common timebase

    logic [31:0] div_r;
    logic        tick_r;
    logic [9:0]  min_div_r;
    logic        min_tick_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r  <= 32'h00000000;
            tick_r <= 1'b0;
        end else if (div_r == TICK_DIV - 1) begin // R21
            div_r  <= 32'h00000000;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 32'h00000001;
            tick_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            min_div_r  <= 10'h000;
            min_tick_r <= 1'b0;
        end else begin
            min_tick_r <= 1'b0;
            if (tick_r) begin
                if (min_div_r == 10'(TICKS_PER_MIN - 1)) begin
                    min_div_r  <= 10'h000;
                    min_tick_r <= 1'b1;
                end else begin
                    min_div_r <= min_div_r + 10'h001;
                end
            end
        end
    end

    // Latest increment seen while its measurement point was healthy
    logic [3:0][24:0] last_good_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_good_r <= '0;
        end else if (proc_in.strobe) begin
            for (int s = 0; s < 4; s++) begin
                if (!point_fail[s % 2]) begin
                    last_good_r[s] <= proc_in.delta[s];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_RELAYS; i++) begin
            force_any_v[i] = ctrl_r[i].force_en;
        end
    end
    assign force_any = |force_any_v; // R18

    ////////////////////////////////////////////////////////////////////////////
    // Per-relay engine

    for (genvar g = 0; g < NUM_RELAYS; g++) begin : g_relay // R19
        rodc_state_t        state_r;
        logic [16:0]        cnt_r;
        logic               pend_r;
        logic               app_req_d_r;
        logic signed [31:0] acc_r;
        logic [15:0]        min_cnt_r;
        logic               cond;
        logic               fs;
        logic               diag_mode;
        logic               vol_mode;
        logic               pulse_req;
        logic               act;
        logic signed [31:0] amt;
        logic signed [31:0] delta_sel;
        logic signed [31:0] acc_add;
        logic               use_delta;
        logic [15:0]        interval_min;
        rodc_ctrl_t         c;

        assign c         = ctrl_r[g];
        assign diag_mode = (c.mode == MODE_STATUS) || (c.mode == MODE_ALARM);
        assign vol_mode  = (c.mode == MODE_EXT_TOT) || (c.mode == MODE_EXT_SMP);
        assign cond      = diag_mode ? |(diag_active & diag_en_r[g]) : 1'b0; // R1

        always_comb begin
            unique case (c.fs_src) // R12
                FSRC_PT1: fs = point_fail[0];
                FSRC_PT2: fs = point_fail[1];
                default:  fs = |point_fail;
            endcase
        end

        // Volume pulses: signed amount, zero amount never fires
        assign amt       = {{7{amount_r[g][24]}}, amount_r[g]};
        assign delta_sel = fs ? {{7{last_good_r[c.pv_sel][24]}}, last_good_r[c.pv_sel]}
                              : {{7{proc_in.delta[c.pv_sel][24]}}, proc_in.delta[c.pv_sel]}; // R7 R11
        assign use_delta = proc_in.strobe && vol_mode && !(fs && !c.fs_count_good); // R11
        assign acc_add   = use_delta ? acc_r + delta_sel : acc_r;
        assign interval_min = 16'(interval_r[g].hours) * 16'd60 + 16'(interval_r[g].minutes);

        always_comb begin
            pulse_req = 1'b0;
            if (vol_mode && amt > 0 && acc_add >= amt) begin // R8
                pulse_req = 1'b1;
            end else if (vol_mode && amt < 0 && acc_add <= amt) begin
                pulse_req = 1'b1;
            end else if (c.mode == MODE_ELAPSED && min_tick_r && interval_min != 16'h0000
                         && min_cnt_r + 16'h0001 >= interval_min) begin // R9
                pulse_req = 1'b1;
            end else if (c.mode == MODE_APP && app_req[g] && !app_req_d_r) begin
                pulse_req = 1'b1;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                acc_r <= 32'sh00000000;
            end else if (!vol_mode) begin
                acc_r <= 32'sh00000000;
            end else if (pulse_req) begin
                acc_r <= acc_add - amt; // R8
            end else begin
                acc_r <= acc_add;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                min_cnt_r   <= 16'h0000;
                app_req_d_r <= 1'b0;
            end else begin
                app_req_d_r <= app_req[g];
                if (c.mode != MODE_ELAPSED) begin
                    min_cnt_r <= 16'h0000;
                end else if (min_tick_r) begin
                    min_cnt_r <= pulse_req ? 16'h0000 : min_cnt_r + 16'h0001;
                end
            end
        end

        // A request during a running pulse is queued once; any further request in the same pulse is lost
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                state_r <= ST_IDLE;
                cnt_r   <= 17'h00000;
                pend_r  <= 1'b0;
            end else if (diag_mode) begin
                pend_r <= 1'b0;
                unique case (state_r)
                    ST_IDLE: begin
                        cnt_r <= 17'h00000;
                        if (cond) begin
                            state_r <= (on_dly_r[g] == 17'h00000) ? ST_ACTIVE : ST_ON_WAIT; // R14
                        end
                    end
                    ST_ON_WAIT: begin
                        if (!cond) begin
                            state_r <= ST_IDLE; // R20
                            cnt_r   <= 17'h00000;
                        end else if (tick_r) begin // R21
                            cnt_r <= cnt_r + 17'h00001;
                            if (cnt_r + 17'h00001 >= on_dly_r[g]) begin
                                state_r <= ST_ACTIVE; // R14
                            end
                        end
                    end
                    ST_ACTIVE: begin
                        cnt_r <= 17'h00000;
                        if (!cond) begin
                            state_r <= ST_OFF_WAIT;
                        end
                    end
                    ST_OFF_WAIT: begin
                        if (cond) begin
                            state_r <= ST_ACTIVE;
                        end else if (tick_r) begin
                            cnt_r <= cnt_r + 17'h00001;
                            if (cnt_r + 17'h00001 >= off_dly_r[g]) begin
                                state_r <= ST_IDLE; // R15
                            end
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end else if (c.mode == MODE_DISABLED) begin
                state_r <= ST_IDLE;
                cnt_r   <= 17'h00000;
                pend_r  <= 1'b0;
            end else begin
                if (state_r != ST_PULSE) begin
                    cnt_r  <= 17'h00000;
                    pend_r <= 1'b0;
                    state_r <= (pulse_req || pend_r) ? ST_PULSE : ST_IDLE;
                end else begin
                    if (pulse_req) begin
                        pend_r <= 1'b1;
                    end
                    if (tick_r) begin
                        cnt_r <= cnt_r + 17'h00001;
                        if (cnt_r + 17'h00001 >= off_dly_r[g]) begin
                            state_r <= ST_IDLE; // R16
                        end
                    end
                end
            end
        end

        assign act = (state_r == ST_ACTIVE) || (state_r == ST_OFF_WAIT) || (state_r == ST_PULSE);

        // Energized and de-energized name the contact itself, so polarity is bypassed
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                relay_out[g] <= 1'b0;
                active_r[g]  <= 1'b0;
                fs_seen[g]   <= 1'b0;
            end else begin
                active_r[g] <= act;
                fs_seen[g]  <= fs;
                if (force_any) begin
                    relay_out[g] <= c.force_val; // R17 R18
                end else if (fs && !vol_mode && c.mode != MODE_DISABLED
                             && c.fs_beh != FS_DISABLED) begin // R10
                    unique case (c.fs_beh)
                        FS_HOLD:     relay_out[g] <= relay_out[g];
                        FS_ENERGIZE: relay_out[g] <= 1'b1;
                        default:     relay_out[g] <= 1'b0;
                    endcase
                end else begin
                    relay_out[g] <= act ^ c.pol_low; // R13
                end
            end
        end
    end

endmodule
`default_nettype wire

// *** test/rodc_relay_ctrl_properties.sv ***
// Checker: APB handshake and relay output properties
`timescale 1ns/1ps
`default_nettype none
module rodc_relay_ctrl_properties
    import rodc_pkg::*;
(
    // Watched ports
    input wire logic                  pclk, presetn, psel, penable, pready, pslverr,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           prdata,
    input wire logic [NUM_RELAYS-1:0] relay_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy_wait; psel && penable && !pready |=> pready; endproperty
    property p_rdy_pulse; pready |=> !pready; endproperty
    property p_rdy_access; pready |-> psel && penable; endproperty
    property p_err_rdy; pslverr |-> pready; endproperty
    property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
    property p_misalign; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
    property p_gap; pready && (paddr[4:0] == 5'h1c || paddr >= 8'hc4) |-> pslverr; endproperty
    property p_rst_idle; $rose(presetn) |-> (relay_out == '0) [*2]; endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
    a_rdy_access: assert property (p_rdy_access) else $error("pready outside access");
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
    a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not cleared");
    a_misalign: assert property (p_misalign) else $error("misaligned not refused");
    a_gap: assert property (p_gap) else $error("unmapped not refused");
    a_rst_idle: assert property (p_rst_idle) else $error("relay busy after reset");
    cover property (pready && pslverr);
    cover property (pready && !pslverr);
    cover property ($rose(relay_out[1]));
endmodule
bind rodc_relay_ctrl rodc_relay_ctrl_properties u_props (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .paddr, .prdata, .relay_out);
`default_nettype wire

// *** test/rodc_contact_model.sv ***
// Partner: pulse counting equipment on the relay contacts
`timescale 1ns/1ps
`default_nettype none
module rodc_contact_model
    import rodc_pkg::*;
(
    // Clock, reset and contacts
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic [NUM_RELAYS-1:0]      relay_out,
    // Pulses seen per contact
    output var  logic [NUM_RELAYS-1:0][7:0] pulse_cnt
);
    logic [NUM_RELAYS-1:0] last_r;
    // Counts rising edges only, as a real totalizer input would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_r <= '0;
            pulse_cnt <= '0;
        end else begin
            last_r <= relay_out;
            for (int i = 0; i < NUM_RELAYS; i++) begin
                if (relay_out[i] && !last_r[i]) begin
                    pulse_cnt[i] <= pulse_cnt[i] + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** test/relay_output_diag_control_test.sv ***
// Testbench: random and corner tests of the relay control block
`timescale 1ns/1ps
`default_nettype none
module relay_output_diag_control_test;
    import rodc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'h5f;
    logic [NUM_DIAG-1:0] diag_active = '0;
    logic [1:0] point_fail = 2'h0;
    logic [NUM_RELAYS-1:0] app_req = '0, relay_out;
    logic [NUM_RELAYS-1:0][7:0] pulse_cnt;
    rodc_proc_t proc_in = '0, p;
    rodc_ctrl_t c;
    int err_count = 0, check_count = 0, tot = 0, amt, n0;
    ////////////////////////////////////////////////////////////////////////////////
    rodc_relay_ctrl #(.TICK_DIV(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .diag_active, .point_fail, .app_req, .proc_in,
        .relay_out);
    rodc_contact_model u_model (.pclk, .presetn, .relay_out, .pulse_cnt);
    initial forever #10 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] ra(int n, logic [4:0] off);
        return 8'(n) * RELAY_STRIDE + 8'(off);
    endfunction
    task automatic cmp(logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cb(logic got, logic exp);
        cmp({31'h0, got}, {31'h0, exp});
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(logic [7:0] a, logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(q, exp);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(10);
        presetn <= 1'b1;
        for (int n = 0; n < NUM_RELAYS; n++) begin
            rc(ra(n, REG_CTRL), 32'h0);
            rc(ra(n, REG_DIAG_EN), 32'h0);
            rc(ra(n, REG_AMOUNT), 32'h3e8);
            rc(ra(n, REG_ON_DLY), 32'h0);
            rc(ra(n, REG_OFF_DLY), 32'h5);
            rc(ra(n, REG_INTERVAL), 32'h10000);
        end
        apb(1'b0, 8'h1c, 32'h0);
        cb(e, 1'b1);
        apb(1'b1, REG_GLOBAL, 32'hffffffff);
        rc(REG_GLOBAL, 32'h0);
        c = '0;
        c.mode = MODE_ELAPSED;
        apb(1'b1, ra(4, REG_CTRL), 32'(c));
        apb(1'b1, ra(4, REG_INTERVAL), 32'h1);
        c.mode = MODE_STATUS;
        apb(1'b1, ra(0, REG_CTRL), 32'(c));
        for (int i = 0; i < NUM_DIAG; i++) begin
            apb(1'b1, ra(0, REG_DIAG_EN), 32'h1 << i);
            diag_active <= ~(19'h1 << i) & 19'(rnd());
            cyc(6);
            cb(relay_out[0], 1'b0);
            diag_active[i] <= 1'b1;
            cyc(4);
            cb(relay_out[0], 1'b1);
            diag_active <= '0;
            cyc(40);
            cb(relay_out[0], 1'b1);
            cyc(30);
            cb(relay_out[0], 1'b0);
        end
        c.pol_low = 1'b1;
        apb(1'b1, ra(0, REG_CTRL), 32'(c));
        cyc(4);
        cb(relay_out[0], 1'b1);
        c.pol_low = 1'b0;
        apb(1'b1, ra(0, REG_CTRL), 32'(c));
        apb(1'b1, ra(0, REG_ON_DLY), 32'h3);
        diag_active[DG_LOG_FULL] <= 1'b1;
        cyc(15);
        diag_active <= '0;
        cyc(30);
        cb(relay_out[0], 1'b0);
        diag_active[DG_LOG_FULL] <= 1'b1;
        cyc(20);
        cb(relay_out[0], 1'b0);
        cyc(20);
        cb(relay_out[0], 1'b1);
        diag_active <= '0;
        cyc(70);
        c.fs_beh = FS_ENERGIZE;
        c.fs_src = FSRC_PT2;
        apb(1'b1, ra(0, REG_CTRL), 32'(c));
        point_fail <= 2'h1;
        cyc(5);
        cb(relay_out[0], 1'b0);
        point_fail <= 2'h2;
        cyc(5);
        cb(relay_out[0], 1'b1);
        point_fail <= 2'h0;
        apb(1'b1, ra(0, REG_CTRL), 32'h0);
        cyc(80);
        c = '0;
        c.force_val = 1'b1;
        apb(1'b1, ra(3, REG_CTRL), 32'(c));
        cyc(4);
        cb(relay_out[3], 1'b0);
        c.force_en = 1'b1;
        apb(1'b1, ra(2, REG_CTRL), 32'(c));
        cyc(4);
        cb(relay_out[3], 1'b1);
        apb(1'b1, ra(2, REG_CTRL), 32'h0);
        apb(1'b1, ra(3, REG_CTRL), 32'h0);
        c = '0;
        c.mode = MODE_EXT_TOT;
        c.pv_sel = 2'(rnd());
        amt = 50 + int'(rnd() % 150);
        apb(1'b1, ra(1, REG_CTRL), 32'(c));
        apb(1'b1, ra(1, REG_AMOUNT), 32'(amt));
        for (int k = 0; k < 13; k++) begin
            p.strobe = 1'b1;
            p.delta = {4{-25'sd7}};
            p.delta[c.pv_sel] = (k == 12) ? 25'(amt) : 25'(rnd() % amt);
            if (k == 12) point_fail <= 2'h3;
            else tot += int'(p.delta[c.pv_sel]);
            proc_in <= p;
            cyc(1);
            proc_in.strobe <= 1'b0;
            cyc(80);
        end
        cmp({24'h0, pulse_cnt[1]}, 32'(tot / amt));
        point_fail <= 2'h0;
        for (int k = 0; k < 13000 && pulse_cnt[4] === 8'h0; k++) cyc(1);
        cb(pulse_cnt[4] != 8'h0, 1'b1);
        print_verdict();
    end
    initial begin
        cyc(60000);
        err_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
